// ### common/lai_consts.svh
/*
  Register indices, field positions, reset values and timing figures
  of the line alarm interrupt status block.
  Assumes nothing; definitions only.
*/
`ifndef LAI_CONSTS_SVH
`define LAI_CONSTS_SVH
`define LAI_CLK_HZ          40000000
`define LAI_SHORT_HOLD_MS   40
`define LAI_LONG_HOLD_S     5.1
`define LAI_TXCLK_LOSS_CYC  70
`define LAI_BER_WIN_BITS    1000
`define LAI_BER_MAX_ERR     10
`define LAI_IDX_MAINT1      6'h0B
`define LAI_IDX_MASK0       6'h11
`define LAI_IDX_MASK1       6'h12
`define LAI_IDX_EDGE        6'h13
`define LAI_IDX_LINE_STATUS_0       6'h14
`define LAI_IDX_LINE_STATUS_1       6'h15
`define LAI_IDX_FLAGS0      6'h16
`define LAI_IDX_FLAGS1      6'h17
`define LAI_IDX_CNTL        6'h18
`define LAI_AUTO_REMOTE_LOOP_ENABLE_BIT        3
`define LAI_RLP_BIT         5
`define LAI_ACT_BIT         6
`define LAI_DEACT_BIT       5
`define LAI_TXCLK_BIT       3
`define LAI_MASK_RST        8'hFF
`define LAI_EDGE_RST        7'h00
`define LAI_CNT_RST         8'h00
`define LAI_RD_ZERO         32'h0000_0000
`endif

// ### common/lai_pkg.sv
/*
  Types and shared decode functions of the line alarm interrupt status block.
  Assumes the constants header is included by the design files.
*/
package lai_pkg;

  typedef enum logic [2:0] {
    LAI_Q_HUNT = 3'h1,
    LAI_Q_ARM  = 3'h2,
    LAI_Q_HELD = 3'h4
  } lai_qual_e;

  typedef struct packed {
    lai_qual_e   st;
    logic [27:0] timer;
    logic [9:0]  win;
    logic [3:0]  errs;
    logic        seen;
  } lai_qual_s;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
  } lai_sync_s;

  typedef struct packed {
    logic [6:0]  edge_sel;
    logic [7:0]  mask0;
    logic [7:0]  mask1;
    logic        auto_loop;
    logic [6:0]  line_status_0;
    logic        remote_loop;
    logic [6:0]  flags0;
    logic [7:0]  flags1;
    logic [7:0]  cnt_low;
    logic [6:0]  clk_idle;
    logic        tx_clk_prev;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } lai_core_s;

  function automatic logic lai_edge_event(input logic prev, input logic cur, input logic sel);
    return (cur & ~prev) | (sel & prev & ~cur);
  endfunction : lai_edge_event

  function automatic logic lai_hit(input logic [7:0] addr, input logic [5:0] idx);
    return (addr[1:0] == 2'h0) && (addr[7:2] == idx);
  endfunction : lai_hit

endpackage : lai_pkg

// ### hw/lai_sync.sv
/*
  Three-stage synchroniser for one pin; the level moves once stages two
  and three agree. Assumes an asynchronous input and one clock.
*/
`timescale 1ns/100ps
module lai_sync
  import lai_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic pin_in,
  output logic      level_out
);
  lai_sync_s s;
  lai_sync_s next_s;

  always_comb begin
    next_s     = s;
    next_s.ff1 = pin_in;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    if (s.ff2 == s.ff3) begin
      next_s.level = s.ff3;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level_out = s.level;
endmodule : lai_sync

// ### hw/lai_code_qual.sv
/*
  Persistence qualifier for one inband loopback code: the seen flag sets
  after an unbroken match for the hold time and then rides out sparse
  bit errors. Assumes a same-clock detector giving a strobe per code bit.
*/
`timescale 1ns/100ps
`include "lai_consts.svh"
module lai_code_qual
  import lai_pkg::*;
#(
  parameter int SHORT_CYC = `LAI_SHORT_HOLD_MS * (`LAI_CLK_HZ / 1000),
  parameter int LONG_CYC  = int'(`LAI_LONG_HOLD_S * `LAI_CLK_HZ),
  parameter int WIN_BITS  = `LAI_BER_WIN_BITS,
  parameter int MAX_ERR   = `LAI_BER_MAX_ERR
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic long_hold_in,
  input  wire logic strobe_in,
  input  wire logic match_in,
  output logic      seen_out
);
  lai_qual_s   s;
  lai_qual_s   next_s;
  logic [27:0] hold_last;

  assign hold_last = long_hold_in ? 28'(LONG_CYC - 1) : 28'(SHORT_CYC - 1);

  always_comb begin
    next_s = s;
    case (s.st)
      LAI_Q_HUNT: begin
        if (strobe_in && match_in) begin
          next_s.st    = LAI_Q_ARM;
          next_s.timer = 28'h0000000;
        end
      end
      LAI_Q_ARM: begin
        next_s.timer = s.timer + 28'h0000001;
        if (strobe_in && !match_in) begin
          next_s.st = LAI_Q_HUNT;
        end else if (s.timer >= hold_last) begin
          next_s.st   = LAI_Q_HELD;
          next_s.seen = 1'b1;
          next_s.win  = 10'h000;
          next_s.errs = 4'h0;
        end
      end
      LAI_Q_HELD: begin
        // Errors are judged per window so a rate, not a single slip, drops the flag
        if (strobe_in) begin
          next_s.win = (s.win == 10'(WIN_BITS - 1)) ? 10'h000 : s.win + 10'h001;
          if (s.win == 10'(WIN_BITS - 1)) begin
            next_s.errs = 4'(!match_in);
          end else begin
            next_s.errs = s.errs + 4'(!match_in);
          end
          if (!match_in && (s.errs == 4'(MAX_ERR - 1))) begin
            next_s.st   = LAI_Q_HUNT;
            next_s.seen = 1'b0;
          end
        end
      end
      default: begin
        next_s.st   = LAI_Q_HUNT;
        next_s.seen = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '{st: LAI_Q_HUNT, timer: 28'h0000000, win: 10'h000, errs: 4'h0, seen: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign seen_out = s.seen;

  a_set_after_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(s.seen) |-> $past(s.timer) == $past(hold_last))
    else $error("code flag set before hold time elapsed");
  a_single_error_held: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s.seen && s.errs == 4'h0 && strobe_in && !match_in |=> s.seen)
    else $error("code flag dropped on one bit error");
endmodule : lai_code_qual

// ### hw/lai_core.sv
/*
  Line alarm status, edge-qualified interrupt latches on it, line event latches,
  remote loopback state and error count low byte for one channel, behind an APB slave.
  Assumes same-clock detector inputs, except the transmit clock pin.
*/
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "lai_consts.svh"
module lai_core
  import lai_pkg::*;
#(
  parameter int SHORT_CYC = `LAI_SHORT_HOLD_MS * (`LAI_CLK_HZ / 1000),
  parameter int LONG_CYC  = int'(`LAI_LONG_HOLD_S * `LAI_CLK_HZ)
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        channel_tx_clock_in,
  input  wire logic        act_code_strobe_in,
  input  wire logic        act_code_match_in,
  input  wire logic        deact_code_strobe_in,
  input  wire logic        deact_code_match_in,
  input  wire logic        pattern_sync_in,
  input  wire logic        driver_short_in,
  input  wire logic        alarm_ind_in,
  input  wire logic        signal_loss_in,
  input  wire logic [7:0]  line_events_in,
  input  wire logic [15:0] error_count_in,
  output logic             remote_loop_out,
  output logic             irq_out
);
  //----------------------------------------------------------------
  // State and reset image
  //----------------------------------------------------------------
  localparam lai_core_s CORE_RST = '{
    edge_sel:    `LAI_EDGE_RST,
    mask0:       `LAI_MASK_RST,
    mask1:       `LAI_MASK_RST,
    auto_loop:   1'b0,
    line_status_0:       7'h00,
    remote_loop: 1'b0,
    flags0:      7'h00,
    flags1:      8'h00,
    cnt_low:     `LAI_CNT_RST,
    clk_idle:    7'h00,
    tx_clk_prev: 1'b0,
    prdata:      `LAI_RD_ZERO,
    pready:      1'b0,
    pslverr:     1'b0,
    irq:         1'b0
  };

  lai_core_s   s;
  lai_core_s   next_s;
  logic        tclk_level;
  logic        activate_code_seen;
  logic        deactivate_code_seen;
  logic [6:0]  idle_next;
  logic        tx_clock_missing;
  logic [6:0]  new_stat;
  logic [6:0]  ev0;
  logic        setup;
  logic        done;
  logic        mapped;
  logic [31:0] rd;
  logic [6:0]  clr0;
  logic [7:0]  clr1;
  logic        act_rise;
  logic        deact_rise;

  //----------------------------------------------------------------
  // Detectors feeding the live status
  //----------------------------------------------------------------
  // The pin filter needs each level to stand two cycles, so a transmit
  // clock faster than a quarter of the master clock reads as missing
  lai_sync u_tclk_sync (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .pin_in    (channel_tx_clock_in),
    .level_out (tclk_level)
  );

  lai_code_qual #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_act_qual (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .long_hold_in (s.auto_loop),
    .strobe_in    (act_code_strobe_in),
    .match_in     (act_code_match_in),
    .seen_out     (activate_code_seen)
  );

  lai_code_qual #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_deact_qual (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .long_hold_in (s.auto_loop),
    .strobe_in    (deact_code_strobe_in),
    .match_in     (deact_code_match_in),
    .seen_out     (deactivate_code_seen)
  );

  // Idle count saturates one past the limit so it never wraps back to "normal"
  assign idle_next = (tclk_level != s.tx_clk_prev) ? 7'h00 :
                     (s.clk_idle > 7'(`LAI_TXCLK_LOSS_CYC)) ? s.clk_idle :
                     s.clk_idle + 7'h01;
  assign tx_clock_missing = idle_next > 7'(`LAI_TXCLK_LOSS_CYC);

  // Real-time flags: activate and deactivate code seen, pattern lock, transmit clock missing, driver short, alarm, signal loss
  assign new_stat = {activate_code_seen, deactivate_code_seen,
                     pattern_sync_in,
                     tx_clock_missing,
                     driver_short_in,
                     alarm_ind_in,
                     signal_loss_in};

  //----------------------------------------------------------------
  // Status change events
  //----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_ev
      assign ev0[g] = lai_edge_event(s.line_status_0[g], new_stat[g], s.edge_sel[g]);
    end
  endgenerate

  assign act_rise   = new_stat[`LAI_ACT_BIT] & ~s.line_status_0[`LAI_ACT_BIT];
  assign deact_rise = new_stat[`LAI_DEACT_BIT] & ~s.line_status_0[`LAI_DEACT_BIT];

  //----------------------------------------------------------------
  // APB decode
  //----------------------------------------------------------------
  assign setup = psel_in & ~penable_in;
  assign done  = psel_in & penable_in & s.pready;

  always_comb begin
    rd     = `LAI_RD_ZERO;
    mapped = 1'b1;
    if (lai_hit(paddr_in, `LAI_IDX_MAINT1)) begin
      rd[`LAI_AUTO_REMOTE_LOOP_ENABLE_BIT] = s.auto_loop;
    end else if (lai_hit(paddr_in, `LAI_IDX_MASK0)) begin
      rd[7:0] = s.mask0;
    end else if (lai_hit(paddr_in, `LAI_IDX_MASK1)) begin
      rd[7:0] = s.mask1;
    end else if (lai_hit(paddr_in, `LAI_IDX_EDGE)) begin
      rd[6:0] = s.edge_sel;
    end else if (lai_hit(paddr_in, `LAI_IDX_LINE_STATUS_0)) begin
      rd[6:0] = s.line_status_0;
    end else if (lai_hit(paddr_in, `LAI_IDX_LINE_STATUS_1)) begin
      rd[`LAI_RLP_BIT] = s.remote_loop;
    end else if (lai_hit(paddr_in, `LAI_IDX_FLAGS0)) begin
      rd[6:0] = s.flags0;
    end else if (lai_hit(paddr_in, `LAI_IDX_FLAGS1)) begin
      rd[7:0] = s.flags1;
    end else if (lai_hit(paddr_in, `LAI_IDX_CNTL)) begin
      rd[7:0] = s.cnt_low;
    end else begin
      mapped = 1'b0;
    end
  end

  // Only bits already shown to software are cleared, so an event that lands
  // between the setup and the access cycle is kept for the next read
  assign clr0 = (done && !pwrite_in && lai_hit(paddr_in, `LAI_IDX_FLAGS0)) ?
                s.prdata[6:0] : 7'h00;
  assign clr1 = (done && !pwrite_in && lai_hit(paddr_in, `LAI_IDX_FLAGS1)) ?
                s.prdata[7:0] : 8'h00;

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  always_comb begin
    next_s             = s;
    next_s.clk_idle    = idle_next;
    next_s.tx_clk_prev = tclk_level;
    next_s.line_status_0       = new_stat;
    next_s.cnt_low     = error_count_in[7:0];

    // Set wins over a clear by read in the same cycle
    next_s.flags0 = (s.flags0 & ~clr0) | ev0;
    next_s.flags1 = (s.flags1 & ~clr1) | line_events_in;

    if (deact_rise) begin
      next_s.remote_loop = 1'b0;
    end else if (act_rise) begin
      next_s.remote_loop = 1'b1;
    end

    if (done && pwrite_in) begin
      if (lai_hit(paddr_in, `LAI_IDX_MAINT1)) begin
        next_s.auto_loop = pwdata_in[`LAI_AUTO_REMOTE_LOOP_ENABLE_BIT];
      end
      if (lai_hit(paddr_in, `LAI_IDX_MASK0)) begin
        next_s.mask0[6:0] = pwdata_in[6:0];
      end
      if (lai_hit(paddr_in, `LAI_IDX_MASK1)) begin
        next_s.mask1 = pwdata_in[7:0];
      end
      if (lai_hit(paddr_in, `LAI_IDX_EDGE)) begin
        next_s.edge_sel = pwdata_in[6:0];
      end
    end

    // No wait state: data and status are registered in the setup cycle
    next_s.pready  = setup;
    next_s.pslverr = setup & ~mapped;
    if (setup) begin
      next_s.prdata = rd;
    end

    next_s.irq = |(next_s.flags0 & ~next_s.mask0[6:0]) |
                 |(next_s.flags1 & ~next_s.mask1);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= CORE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_out      = s.prdata;
  assign pready_out      = s.pready;
  assign pslverr_out     = s.pslverr;
  assign remote_loop_out = s.remote_loop;
  assign irq_out         = s.irq;

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  a_rise_latches: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(s.line_status_0[0]) |-> s.flags0[0])
    else $error("rising status did not latch event");

  a_fall_ignored: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(s.line_status_0[1]) && !$past(s.edge_sel[1]) && !$past(s.flags0[1]) |-> !s.flags0[1])
    else $error("falling status latched with rising-only select");

  a_fall_selected: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(s.line_status_0[2]) && $past(s.edge_sel[2]) |-> s.flags0[2])
    else $error("falling status not latched with any-change select");

  a_irq_masked: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s.mask0[6:0] == 7'h7F && s.mask1 == 8'hFF |-> !irq_out)
    else $error("interrupt raised while all sources masked");

  a_irq_follows: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(s.flags1[0]) && !s.mask1[0] |-> irq_out ##1 (irq_out || clr1[0] || $fell(s.flags1[0])))
    else $error("unmasked event did not raise interrupt");

  a_clk_missing: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(s.line_status_0[`LAI_TXCLK_BIT]) |-> s.clk_idle == 7'(`LAI_TXCLK_LOSS_CYC + 1))
    else $error("clock loss flagged at wrong idle count");

  a_clk_present: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s.clk_idle <= 7'(`LAI_TXCLK_LOSS_CYC) |-> !s.line_status_0[`LAI_TXCLK_BIT])
    else $error("clock loss flagged while clock toggles");

  a_read_clear0: assert property (@(posedge clk_in) disable iff (!nrst_in)
    done && !pwrite_in && lai_hit(paddr_in, `LAI_IDX_FLAGS0)
    |=> (s.flags0 & $past(s.prdata[6:0]) & ~$past(ev0)) == 7'h00)
    else $error("first event register not cleared by read");

  a_read_clear1: assert property (@(posedge clk_in) disable iff (!nrst_in)
    done && !pwrite_in && lai_hit(paddr_in, `LAI_IDX_FLAGS1)
    |=> (s.flags1 & $past(s.prdata[7:0]) & ~$past(line_events_in)) == 8'h00)
    else $error("second event register not cleared by read");

  a_line_latch: assert property (@(posedge clk_in) disable iff (!nrst_in)
    line_events_in[7] |=> s.flags1[7])
    else $error("line event not latched");

  a_loop_close: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(s.line_status_0[`LAI_ACT_BIT]) && !$rose(s.line_status_0[`LAI_DEACT_BIT]) |-> s.remote_loop)
    else $error("activate code did not close remote loop");

  a_loop_open: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(s.line_status_0[`LAI_DEACT_BIT]) |-> !s.remote_loop)
    else $error("deactivate code did not open remote loop");

  a_line_status_1_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    setup && lai_hit(paddr_in, `LAI_IDX_LINE_STATUS_1)
    |=> s.prdata == {26'h0000000, $past(s.remote_loop), 5'h00})
    else $error("loop status read wrong");

  a_cnt_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s.cnt_low == $past(error_count_in[7:0]))
    else $error("error count low byte not tracking");

  a_apb_answer: assert property (@(posedge clk_in) disable iff (!nrst_in)
    setup |=> pready_out ##1 !pready_out)
    else $error("apb answer not one cycle after setup");

  a_irq_unmasked: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (|(s.flags0 & ~s.mask0[6:0]) || |(s.flags1 & ~s.mask1)) |-> irq_out)
    else $error("unmasked latched event without interrupt");

  a_irq_source: assert property (@(posedge clk_in) disable iff (!nrst_in)
    irq_out |-> (|(s.flags0 & ~s.mask0[6:0]) || |(s.flags1 & ~s.mask1)))
    else $error("interrupt without unmasked latched event");

  a_event_cause: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ((s.flags0 & ~$past(s.flags0)) & ~(s.line_status_0 ^ $past(s.line_status_0))) == 7'h00)
    else $error("event latched without status change");

  a_loop_ctrl_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    done && pwrite_in && lai_hit(paddr_in, `LAI_IDX_MAINT1)
    |=> s.auto_loop == $past(pwdata_in[`LAI_AUTO_REMOTE_LOOP_ENABLE_BIT]))
    else $error("auto loop enable write lost");

  a_mask_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    done && pwrite_in && lai_hit(paddr_in, `LAI_IDX_MASK1)
    |=> s.mask1 == $past(pwdata_in[7:0]))
    else $error("mask write lost");
endmodule : lai_core

// ### verif/lai_core_tb.sv
/*
  Self-checking bench for the line alarm interrupt status core.
  Assumes the APB slave answers in its own time and shortened code hold counts.
*/
`timescale 1ns/100ps
`include "lai_consts.svh"
module testbench;
  import lai_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int SC = 20;
  localparam int LC = 50;
  logic        clk_in = 1'h0;
  logic        nrst   = 1'h0;
  logic        psel   = 1'h0;
  logic        pen    = 1'h0;
  logic        pwr    = 1'h0;
  logic        txc    = 1'h0;
  logic        tx_run = 1'h1;
  logic        as     = 1'h0;
  logic        am     = 1'h0;
  logic        ds     = 1'h0;
  logic        dm     = 1'h0;
  logic [7:0]  paddr  = 8'h00;
  logic [7:0]  lev    = 8'h00;
  logic [7:0]  b;
  logic [7:0]  v;
  logic [3:0]  lv     = 4'h0;
  logic [15:0] ec     = 16'h0000;
  logic [31:0] pwd    = 32'h0;
  logic [31:0] prd;
  logic [31:0] rdv;
  logic        pready;
  logic        perr;
  logic        erv;
  logic        rloop;
  logic        irq;
  int          n_fail = 0;
  int          n_compared = 0;
  integer      seed = 32'hBD594D76;

  lai_core #(.SHORT_CYC(SC), .LONG_CYC(LC)) lai_core_i (
    .clk_in(clk_in), .nrst_in(nrst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(pready), .pslverr_out(perr), .channel_tx_clock_in(txc),
    .act_code_strobe_in(as), .act_code_match_in(am),
    .deact_code_strobe_in(ds), .deact_code_match_in(dm),
    .pattern_sync_in(lv[3]), .driver_short_in(lv[2]), .alarm_ind_in(lv[1]),
    .signal_loss_in(lv[0]), .line_events_in(lev), .error_count_in(ec),
    .remote_loop_out(rloop), .irq_out(irq));

  always #12.5 clk_in = ~clk_in;

  // Each transmit clock level stands four cycles: a pin that toggles every
  // cycle never passes the agreement filter and would read as missing
  logic [1:0]  txdiv  = 2'h0;
  always @(posedge clk_in) begin
    if (tx_run) begin
      txdiv <= txdiv + 2'h1;
      if (txdiv == 2'h3) txc <= ~txc;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Idle edge after release so registered side effects have landed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1'h1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rdv = prd;
    erv = perr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk_in);
  endtask : apb

  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    apb(1'h1, {ix, 2'h0}, {24'h0, d});
  endtask : wr

  task automatic rdc(input logic [5:0] ix, input logic [7:0] e);
    apb(1'h0, {ix, 2'h0}, 32'h0);
    chk($sformatf("reg %h", ix), rdv, {24'h0, e});
  endtask : rdc

  // Status register image from the level inputs and the clock-missing flag
  function automatic logic [7:0] stat_exp(input logic [3:0] l, input logic miss);
    return {3'h0, l[3], miss, l[2:0]};
  endfunction : stat_exp

  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(20);
    nrst <= 1'h1;
    cyc(2);
    rdc(`LAI_IDX_MASK0, 8'hFF);
    rdc(`LAI_IDX_MASK1, 8'hFF);
    rdc(`LAI_IDX_EDGE, 8'h00);
    rdc(`LAI_IDX_MAINT1, 8'h00);
    rdc(`LAI_IDX_CNTL, 8'h00);
    rdc(`LAI_IDX_LINE_STATUS_1, 8'h00);
    apb(1'h0, 8'hFC, 32'h0);
    chk("slverr", erv, 1'h1);
    for (int j = 0; j < 6; j++) begin
      lv <= 4'($random(seed));
      cyc(3);
      rdc(`LAI_IDX_LINE_STATUS_0, stat_exp(lv, 1'h0));
    end
    for (int i = 0; i < 4; i++) begin
      for (int es = 0; es < 2; es++) begin
        b = (i == 3) ? 8'h10 : 8'h01 << i;
        wr(`LAI_IDX_EDGE, es ? b : 8'h00);
        wr(`LAI_IDX_MASK0, ~b);
        lv <= 4'h0;
        cyc(3);
        apb(1'h0, {`LAI_IDX_FLAGS0, 2'h0}, 32'h0);
        lv[i] <= 1'h1;
        cyc(3);
        chk("irq", irq, 1'h1);
        rdc(`LAI_IDX_FLAGS0, b);
        chk("irq", irq, 1'h0);
        lv[i] <= 1'h0;
        cyc(3);
        chk("irq", irq, es[0]);
        rdc(`LAI_IDX_FLAGS0, es ? b : 8'h00);
        rdc(`LAI_IDX_FLAGS0, 8'h00);
      end
    end
    wr(`LAI_IDX_MASK0, 8'hFF);
    lv[0] <= 1'h1;
    cyc(3);
    chk("irq", irq, 1'h0);
    rdc(`LAI_IDX_FLAGS0, 8'h01);
    lv <= 4'h0;
    wr(`LAI_IDX_MASK1, 8'h00);
    for (int j = 0; j < 2; j++) begin
      v = j ? 8'hFF : (8'($random(seed)) | 8'h01);
      lev <= v;
      @(posedge clk_in);
      lev <= 8'h00;
      cyc(2);
      chk("irq", irq, 1'h1);
      rdc(`LAI_IDX_FLAGS1, v);
      chk("irq", irq, 1'h0);
      rdc(`LAI_IDX_FLAGS1, 8'h00);
    end
    for (int j = 0; j < 3; j++) begin
      ec <= 16'($random(seed));
      cyc(2);
      rdc(`LAI_IDX_CNTL, ec[7:0]);
    end
    // Filter latency and the clock divider phase fit inside both margins
    tx_run <= 1'h0;
    cyc(60);
    rdc(`LAI_IDX_LINE_STATUS_0, stat_exp(lv, 1'h0));
    cyc(20);
    rdc(`LAI_IDX_LINE_STATUS_0, stat_exp(lv, 1'h1));
    tx_run <= 1'h1;
    cyc(10);
    rdc(`LAI_IDX_LINE_STATUS_0, stat_exp(lv, 1'h0));
    as <= 1'h1;
    am <= 1'h1;
    cyc(10);
    rdc(`LAI_IDX_LINE_STATUS_0, 8'h00);
    cyc(SC);
    rdc(`LAI_IDX_LINE_STATUS_0, 8'h40);
    chk("loop", rloop, 1'h1);
    rdc(`LAI_IDX_LINE_STATUS_1, 8'h20);
    am <= 1'h0;
    cyc(3);
    am <= 1'h1;
    rdc(`LAI_IDX_LINE_STATUS_0, 8'h40);
    as <= 1'h0;
    ds <= 1'h1;
    dm <= 1'h1;
    cyc(SC + 10);
    chk("loop", rloop, 1'h0);
    rdc(`LAI_IDX_LINE_STATUS_1, 8'h00);
    am <= 1'h0;
    dm <= 1'h0;
    as <= 1'h1;
    cyc(14);
    as <= 1'h0;
    ds <= 1'h0;
    rdc(`LAI_IDX_LINE_STATUS_0, 8'h00);
    wr(`LAI_IDX_MAINT1, 8'h08);
    rdc(`LAI_IDX_MAINT1, 8'h08);
    as <= 1'h1;
    am <= 1'h1;
    cyc(35);
    rdc(`LAI_IDX_LINE_STATUS_0, 8'h00);
    cyc(LC - 25);
    rdc(`LAI_IDX_LINE_STATUS_0, 8'h40);
    as <= 1'h0;
    complete_run();
  end

  // Whole sequence needs well under 3000 cycles
  initial begin
    cyc(20000);
    n_fail++;
    complete_run();
  end
endmodule : testbench
